//--- logic/data_pointer_pkg.sv
// constants for the dual data-pointer unit
// assumes the core reaches the auxiliary register over its internal sfr path
package data_pointer_pkg;
    localparam logic [7:0]  AUX_POINTER_CONTROL_ADDR = 8'hA2;
    localparam int          SELECT_BIT_POS           = 0;
    localparam logic        SELECT_RESET             = 1'h0;
    localparam logic [15:0] POINTER_RESET            = 16'h0000;
    localparam logic [7:0]  RESERVED_READ            = 8'h00;
    localparam int          INC_INSTR_BYTES          = 2;
    localparam int          INC_INSTR_CLOCKS         = 12;
    typedef enum logic [1:0]
    {
        PTR_OP_NONE,
        PTR_OP_LOAD,
        PTR_OP_INC
    } ptr_op_type;
endpackage

//--- logic/pointer_pair.sv
// two 16-bit pointer registers, one of them selected for each operation
// assumes op and select are synchronous to clk_in
`timescale 1ns/1ns
module pointer_pair
    import data_pointer_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic        select_in,
    input  wire ptr_op_type  op_in,
    input  wire logic [15:0] load_value_in,
    output logic      [15:0] pointer_zero_out,
    output logic      [15:0] pointer_one_out
);
    logic [15:0] pointer_zero_reg;
    logic [15:0] pointer_zero_next;
    logic [15:0] pointer_one_reg;
    logic [15:0] pointer_one_next;

    function automatic logic [15:0] apply_op(input ptr_op_type op, input logic [15:0] cur, input logic [15:0] ld);
        case (op)
            PTR_OP_LOAD: apply_op = ld;
            PTR_OP_INC:  apply_op = cur + 16'h0001;
            default:     apply_op = cur;
        endcase
    endfunction

    always_comb
    begin
        pointer_zero_next = pointer_zero_reg;
        pointer_one_next  = pointer_one_reg;
        if (select_in)
            pointer_one_next = apply_op(op_in, pointer_one_reg, load_value_in);
        else
            pointer_zero_next = apply_op(op_in, pointer_zero_reg, load_value_in);
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            pointer_zero_reg <= POINTER_RESET;
            pointer_one_reg  <= POINTER_RESET;
        end
        else
        begin
            pointer_zero_reg <= pointer_zero_next;
            pointer_one_reg  <= pointer_one_next;
        end
    end

    assign pointer_zero_out = pointer_zero_reg;
    assign pointer_one_out  = pointer_one_reg;
endmodule

//--- logic/dual_data_pointer_select.sv
// dual data-pointer unit: select bit register, pointer pair, active pointer out
// assumes the core presents one sfr access or pointer op per cycle
`timescale 1ns/1ns
module dual_data_pointer_select
    import data_pointer_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic [7:0]  sfr_addr_in,
    input  wire logic        sfr_write_in,
    input  wire logic [7:0]  sfr_wdata_in,
    input  wire logic        sfr_inc_in,
    input  wire logic        sfr_bit_write_in,
    input  wire ptr_op_type  ptr_op_in,
    input  wire logic [15:0] ptr_load_in,
    output logic [7:0]       sfr_rdata_out,
    output logic             pointer_select_bit_out,
    output logic [15:0]      data_pointer_out
);
    ////////////////////////////////////////////////////////////////////////////////
    logic        pointer_select_bit_reg;
    logic        pointer_select_bit_next;
    logic [7:0]  sfr_rdata_reg;
    logic [7:0]  sfr_rdata_next;
    logic [15:0] data_pointer_reg;
    logic [15:0] data_pointer_next;
    logic [15:0] pointer_zero;
    logic [15:0] pointer_one;
    logic        aux_hit;

    assign aux_hit = (sfr_addr_in == AUX_POINTER_CONTROL_ADDR);

    ////////////////////////////////////////////////////////////////////////////////
    // select bit: byte write loads bit 0, increment toggles; bit writes ignored
    always_comb
    begin
        pointer_select_bit_next = pointer_select_bit_reg;
        if (aux_hit && sfr_inc_in)
            pointer_select_bit_next = ~pointer_select_bit_reg;
        else if (aux_hit && sfr_write_in)
            pointer_select_bit_next = sfr_wdata_in[SELECT_BIT_POS];
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            pointer_select_bit_reg <= SELECT_RESET;
        else
            pointer_select_bit_reg <= pointer_select_bit_next;
    end

    ////////////////////////////////////////////////////////////////////////////////
    pointer_pair pair_inst
    (
        .clk_in           (clk_in),
        .reset_in         (reset_in),
        .select_in        (pointer_select_bit_reg),
        .op_in            (ptr_op_in),
        .load_value_in    (ptr_load_in),
        .pointer_zero_out (pointer_zero),
        .pointer_one_out  (pointer_one)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // registered outputs: read data loads the next select bit, so it matches the select bit; active pointer follows state by one cycle
    always_comb
    begin
        sfr_rdata_next = RESERVED_READ;
        sfr_rdata_next[SELECT_BIT_POS] = pointer_select_bit_next;
        data_pointer_next = pointer_select_bit_reg ? pointer_one : pointer_zero;
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            sfr_rdata_reg    <= RESERVED_READ;
            data_pointer_reg <= POINTER_RESET;
        end
        else
        begin
            sfr_rdata_reg    <= sfr_rdata_next;
            data_pointer_reg <= data_pointer_next;
        end
    end

    assign sfr_rdata_out          = sfr_rdata_reg;
    assign pointer_select_bit_out = pointer_select_bit_reg;
    assign data_pointer_out       = data_pointer_reg;

    ////////////////////////////////////////////////////////////////////////////////
    AST_RESET_CLEARS_SELECT: assert property (@(posedge clk_in) reset_in |=> !pointer_select_bit_out)
        else $error("select bit not cleared by reset");

    AST_INC_TOGGLES: assert property (@(posedge clk_in) disable iff (reset_in)
        (aux_hit && sfr_inc_in) |=> (pointer_select_bit_out != $past(pointer_select_bit_out)))
        else $error("increment did not toggle select bit");

    AST_WRITE_LOADS_BIT0: assert property (@(posedge clk_in) disable iff (reset_in)
        (aux_hit && sfr_write_in && !sfr_inc_in) |=> (pointer_select_bit_out == $past(sfr_wdata_in[0])))
        else $error("byte write did not load select bit");

    AST_BIT_WRITE_IGNORED: assert property (@(posedge clk_in) disable iff (reset_in)
        (sfr_bit_write_in && !sfr_write_in && !sfr_inc_in) |=> $stable(pointer_select_bit_out))
        else $error("bit write changed select bit");

    AST_RESERVED_ZERO: assert property (@(posedge clk_in) disable iff (reset_in)
        sfr_rdata_out[7:1] == 7'h00)
        else $error("reserved bits not zero");

    AST_ACTIVE_POINTER: assert property (@(posedge clk_in) disable iff (reset_in)
        ##1 data_pointer_out == ($past(pointer_select_bit_out) ? $past(pointer_one) : $past(pointer_zero)))
        else $error("active pointer does not follow select bit");

    AST_UNSELECTED_HOLDS_ZERO: assert property (@(posedge clk_in) disable iff (reset_in)
        pointer_select_bit_out |=> $stable(pointer_zero))
        else $error("unselected pointer zero changed");

    AST_UNSELECTED_HOLDS_ONE: assert property (@(posedge clk_in) disable iff (reset_in)
        !pointer_select_bit_out |=> $stable(pointer_one))
        else $error("unselected pointer one changed");

    AST_INC_SELECTED: assert property (@(posedge clk_in) disable iff (reset_in)
        (ptr_op_in == PTR_OP_INC && !pointer_select_bit_out) |=> (pointer_zero == $past(pointer_zero) + 16'h0001))
        else $error("pointer zero not incremented");

    AST_INC_SELECTED_ONE: assert property (@(posedge clk_in) disable iff (reset_in)
        (ptr_op_in == PTR_OP_INC && pointer_select_bit_out) |=> (pointer_one == $past(pointer_one) + 16'h0001))
        else $error("pointer one not incremented");

    AST_LOAD_SELECTED_ZERO: assert property (@(posedge clk_in) disable iff (reset_in)
        (ptr_op_in == PTR_OP_LOAD && !pointer_select_bit_out) |=> (pointer_zero == $past(ptr_load_in)))
        else $error("pointer zero not loaded");

    AST_LOAD_SELECTED_ONE: assert property (@(posedge clk_in) disable iff (reset_in)
        (ptr_op_in == PTR_OP_LOAD && pointer_select_bit_out) |=> (pointer_one == $past(ptr_load_in)))
        else $error("pointer one not loaded");

    AST_NO_OP_HOLDS: assert property (@(posedge clk_in) disable iff (reset_in)
        (ptr_op_in == PTR_OP_NONE) |=> ($stable(pointer_zero) && $stable(pointer_one)))
        else $error("pointer changed without an op");

    AST_OTHER_ADDR_IGNORED: assert property (@(posedge clk_in) disable iff (reset_in)
        !aux_hit |=> $stable(pointer_select_bit_out))
        else $error("access to another address changed select bit");

    AST_RDATA_FOLLOWS_SELECT: assert property (@(posedge clk_in) disable iff (reset_in)
        sfr_rdata_out[0] == pointer_select_bit_out)
        else $error("read data bit 0 differs from select bit");

    AST_RESET_CLEARS_POINTER: assert property (@(posedge clk_in) reset_in |=> (data_pointer_out == POINTER_RESET))
        else $error("active pointer not cleared by reset");
endmodule

//--- testbench/core_model.sv
// stand-in for the cpu core: issues sfr accesses and pointer ops
// assumes the bench calls step and idle; every change lands on a falling edge
`timescale 1ns/1ns
module core_model
    import data_pointer_pkg::*;
(
    input  wire logic  clk_in,
    output logic [7:0] sfr_addr_out,
    output logic       sfr_write_out,
    output logic [7:0] sfr_wdata_out,
    output logic       sfr_inc_out,
    output logic       sfr_bit_write_out,
    output ptr_op_type ptr_op_out,
    output logic [15:0] ptr_load_out
);
    initial
    begin
        sfr_addr_out      = 8'h00;
        sfr_write_out     = 1'b0;
        sfr_wdata_out     = 8'h00;
        sfr_inc_out       = 1'b0;
        sfr_bit_write_out = 1'b0;
        ptr_op_out        = PTR_OP_NONE;
        ptr_load_out      = 16'h0000;
    end
    // one instruction held for one cycle; reserved data bits always sent as zero
    task automatic step(input logic [7:0] a, input logic w, input logic i, input logic b,
                        input logic d, input ptr_op_type op, input logic [15:0] v);
        @(negedge clk_in);
        sfr_addr_out      = a;
        sfr_write_out     = w;
        sfr_wdata_out     = {7'h00, d};
        sfr_inc_out       = i;
        sfr_bit_write_out = b;
        ptr_op_out        = op;
        ptr_load_out      = v;
    endtask
    // released lines do not keep their last value
    task automatic idle();
        @(negedge clk_in);
        sfr_addr_out      = ~sfr_addr_out;
        sfr_write_out     = 1'b0;
        sfr_wdata_out     = ~sfr_wdata_out;
        sfr_inc_out       = 1'b0;
        sfr_bit_write_out = 1'b0;
        ptr_op_out        = PTR_OP_NONE;
        ptr_load_out      = ~ptr_load_out;
    endtask
endmodule

//--- testbench/tb.sv
// self-checking bench for the dual data-pointer unit
// assumes core_model drives every design input except clk_in and reset_in
`timescale 1ns/1ns
module tb;
    import data_pointer_pkg::*;
    logic        clk_in;
    logic        reset_in;
    logic [7:0]  addr, wdata, rdata;
    logic        wr, inc, bwr, sel;
    ptr_op_type  op;
    logic [15:0] load, dp;
    int          mismatches = 0;
    int          tests_run = 0;
    int          cycles = 0;
    core_model core (.clk_in(clk_in), .sfr_addr_out(addr), .sfr_write_out(wr), .sfr_wdata_out(wdata),
        .sfr_inc_out(inc), .sfr_bit_write_out(bwr), .ptr_op_out(op), .ptr_load_out(load));
    dual_data_pointer_select u_dual_data_pointer_select (.clk_in(clk_in), .reset_in(reset_in),
        .sfr_addr_in(addr), .sfr_write_in(wr), .sfr_wdata_in(wdata), .sfr_inc_in(inc),
        .sfr_bit_write_in(bwr), .ptr_op_in(op), .ptr_load_in(load), .sfr_rdata_out(rdata),
        .pointer_select_bit_out(sel), .data_pointer_out(dp));
    initial
    begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            mismatches++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (mismatches == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one sfr instruction, then select bit and read data one cycle on
    task automatic sfr(input logic [7:0] a, input logic w, input logic i, input logic b,
                       input logic d, input logic s);
        core.step(a, w, i, b, d, PTR_OP_NONE, 16'h0000);
        core.idle();
        chk({15'h0000, sel}, {15'h0000, s});
        if (a == AUX_POINTER_CONTROL_ADDR)
            chk({8'h00, rdata}, {8'h00, RESERVED_READ | {7'h00, s}});
    endtask
    // one pointer op, then the active pointer two cycles on
    task automatic ptr(input ptr_op_type o, input logic [15:0] v, input logic [15:0] exp);
        core.step(8'h00, 1'b0, 1'b0, 1'b0, 1'b0, o, v);
        core.idle();
        @(negedge clk_in);
        chk(dp, exp);
    endtask
    // source and destination pointers walked alternately
    task automatic block_copy();
        ptr(PTR_OP_LOAD, 16'h9000, 16'h9000);
        sfr(8'hA2, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        ptr(PTR_OP_NONE, 16'h0000, POINTER_RESET);
        ptr(PTR_OP_LOAD, 16'hA000, 16'hA000);
        sfr(8'hA2, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        ptr(PTR_OP_INC, 16'h0000, 16'h9001);
        sfr(8'hA2, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        ptr(PTR_OP_INC, 16'h0000, 16'hA001);
        sfr(8'hA2, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        ptr(PTR_OP_NONE, 16'h0000, 16'h9001);
        ptr(PTR_OP_LOAD, 16'hFFFF, 16'hFFFF);
        ptr(PTR_OP_INC, 16'h0000, 16'h0000);
    endtask
    // reset in mid-run clears select bit and both pointers
    task automatic reset_mid();
        sfr(8'hA2, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
        ptr(PTR_OP_LOAD, 16'h1234, 16'h1234);
        reset_in = 1'b1;
        repeat (2) @(negedge clk_in);
        reset_in = 1'b0;
        chk({15'h0000, sel}, 16'h0000);
        chk({8'h00, rdata}, 16'h0000);
        chk(dp, POINTER_RESET);
        sfr(8'hA2, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
        ptr(PTR_OP_NONE, 16'h0000, POINTER_RESET);
    endtask
    initial
    begin
        reset_in = 1'b1;
        repeat (10) @(negedge clk_in);
        reset_in = 1'b0;
        chk({15'h0000, sel}, 16'h0000);
        chk({8'h00, rdata}, 16'h0000);
        chk(dp, POINTER_RESET);
        sfr(8'hA2, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
        sfr(8'hA3, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        sfr(8'hA2, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        sfr(8'hA2, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        sfr(8'hA2, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        sfr(8'hA2, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        sfr(8'hA3, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        block_copy();
        reset_mid();
        finish_test();
    end
endmodule
